// File: rtl/scm_safety_cfg.sv
// scm_safety_cfg: safety-check control register, error pin window registers and error pin monitor
// assumes a command decoder on clk_i delivering one register access per valid cycle
//
// Function
// - control register writes take effect only while the control lock is clear.
// - control register resets on power-on and device reset; windows on power-on only.
// - window registers are writable only in diagnostic state with configuration lock clear.
// - checksum enable set runs a continuous CRC8 check over configuration; clear disables it.
// - drive output enable clears automatically on entry to the safe state.
// - drive enable pin low when bit clear; high only in active or diagnostic.
// - pin high only if watchdog and monitor failure counts stay below thresholds.
// - error monitor runs only while its enable bit is set.
// - leave request settable only in diagnostic state, cleared on leaving it.
// - leave request with leave block clear moves diagnostic to active.
// - pulse-width mode high-phase limits are (field plus one) times 15 us.
// - low-phase limit is (field plus one) times 15 us, or 5 us in legacy.
// - mode select 1 is pulse-width, 0 legacy; low limit applies in both.
// - control bits 7 to 5 and 1 read zero and are read-only.
`default_nettype none
`include "scm_consts.svh"
module scm_safety_cfg #(
   parameter int FC_WIDTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_on_reset_i,
   input wire logic cmd_valid_i,
   input wire scm_pkg::scm_cmd_type cmd_i,
   input wire logic ctrl_lock_i,
   input wire logic cfg_lock_i,
   input wire scm_pkg::scm_state_type dev_state_i,
   input wire logic diagnostic_leave_block_i,
   input wire logic error_monitor_mode_select_i,
   input wire logic [7:0] expected_config_checksum_i,
   input wire scm_pkg::scm_fail_type fail_i,
   input wire logic error_pin_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic drive_enable_pin_o,
   output logic diagnostic_leave_o,
   output logic checksum_error_o,
   output logic error_monitor_event_o,
   output logic [FC_WIDTH-1:0] error_monitor_fail_count_o
);
   localparam logic [8:0] STEP_PWM = 9'((`SCM_STEP_PWM_NS * `SCM_CLK_KHZ) / 1000000);
   localparam logic [8:0] STEP_LEGACY = 9'((`SCM_STEP_LEGACY_NS * `SCM_CLK_KHZ) / 1000000);
   localparam logic [7:0] CTRL_RST = `SCM_RST_CTRL;

   function automatic logic [7:0] crc8(input logic [31:0] data);
      logic [7:0] c;
      c = `SCM_CRC_INIT;
      for (int i = 31; i >= 0; i--) begin
         c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ `SCM_CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   logic crc_en, drive_en, esm_en, leave_req;
   logic [7:0] high_max, high_min, low_max;
   logic in_diag, ctrl_wr, win_wr, was_safe;
   assign in_diag = (dev_state_i == scm_pkg::SCM_DIAG);
   assign ctrl_wr = cmd_valid_i && cmd_i.write && (cmd_i.index == `SCM_IDX_CTRL) && !ctrl_lock_i;
   assign win_wr = cmd_valid_i && cmd_i.write && in_diag && !cfg_lock_i;

   ////////////////////////////////////////////////////////////////////////////
   // control register

   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i) begin
         crc_en <= CTRL_RST[`SCM_BIT_CRC_EN];
         esm_en <= CTRL_RST[`SCM_BIT_ESM_EN];
      end else if (ctrl_wr) begin
         crc_en <= cmd_i.wdata[`SCM_BIT_CRC_EN];
         esm_en <= cmd_i.wdata[`SCM_BIT_ESM_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      was_safe <= (dev_state_i == scm_pkg::SCM_SAFE);
   end

   // safe entry wins over a same-cycle write so the pin cannot stay armed
   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i) begin
         drive_en <= 1'b0;
      end else if (dev_state_i == scm_pkg::SCM_SAFE && !was_safe) begin
         drive_en <= 1'b0;
      end else if (ctrl_wr) begin
         drive_en <= cmd_i.wdata[`SCM_BIT_DRV_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i) begin
         leave_req <= 1'b0;
      end else if (!in_diag) begin
         leave_req <= 1'b0;
      end else if (ctrl_wr) begin
         leave_req <= cmd_i.wdata[`SCM_BIT_LEAVE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // window registers, power-on reset only

   always_ff @(posedge clk_i) begin
      if (power_on_reset_i) begin
         high_max <= `SCM_RST_HMAX;
         high_min <= `SCM_RST_HMIN;
         low_max <= `SCM_RST_LMAX;
      end else if (win_wr) begin
         if (cmd_i.index == `SCM_IDX_HMAX) begin
            high_max <= cmd_i.wdata;
         end
         if (cmd_i.index == `SCM_IDX_HMIN) begin
            high_min <= cmd_i.wdata;
         end
         if (cmd_i.index == `SCM_IDX_LMAX) begin
            low_max <= cmd_i.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port, answer one cycle after the command

   logic [7:0] next_rd_data;
   always_comb begin
      case (cmd_i.index)
         `SCM_IDX_CTRL: begin
            next_rd_data = 8'h00;
            next_rd_data[`SCM_BIT_CRC_EN] = crc_en;
            next_rd_data[`SCM_BIT_DRV_EN] = drive_en;
            next_rd_data[`SCM_BIT_ESM_EN] = esm_en;
            next_rd_data[`SCM_BIT_LEAVE] = leave_req;
         end
         `SCM_IDX_HMAX: next_rd_data = high_max;
         `SCM_IDX_HMIN: next_rd_data = high_min;
         `SCM_IDX_LMAX: next_rd_data = low_max;
         default: next_rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i) begin
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= cmd_valid_i && !cmd_i.write;
         if (cmd_valid_i && !cmd_i.write) begin
            rd_data_o <= next_rd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // diagnostic exit, drive pin, checksum

   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i) begin
         diagnostic_leave_o <= 1'b0;
         drive_enable_pin_o <= 1'b0;
         checksum_error_o <= 1'b0;
      end else begin
         diagnostic_leave_o <= in_diag && leave_req && !diagnostic_leave_block_i;
         drive_enable_pin_o <= drive_en
            && (in_diag || dev_state_i == scm_pkg::SCM_ACTIVE)
            && (fail_i.wd_count < fail_i.wd_drive_th)
            && (fail_i.wd_count < fail_i.wd_reset_th)
            && (error_monitor_fail_count_o < FC_WIDTH'(fail_i.esm_drive_th));
         // full recompute each cycle keeps the check continuous at the cost of a wide xor tree
         checksum_error_o <= crc_en
            && (crc8({high_max, high_min, low_max, 7'h00, error_monitor_mode_select_i})
               != expected_config_checksum_i);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error pin monitor

   logic pin_meta, pin_sync, pin_last, pin_edge;
   logic [8:0] step_cnt;
   logic [8:0] phase_ticks;
   logic overrun_done;
   logic step_tick, phase_err;
   logic [8:0] step_len;

   always_ff @(posedge clk_i) begin
      pin_meta <= error_pin_i;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
   end

   assign pin_edge = pin_sync != pin_last;
   assign step_len = error_monitor_mode_select_i ? STEP_PWM : STEP_LEGACY;
   assign step_tick = (step_cnt == step_len - 9'h001);

   // timebase restarts on every edge so phase length is measured from the edge
   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i || !esm_en || pin_edge || step_tick) begin
         step_cnt <= 9'h000;
      end else begin
         step_cnt <= step_cnt + 9'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i || !esm_en || pin_edge) begin
         phase_ticks <= 9'h000;
      end else if (step_tick && phase_ticks != 9'h1ff) begin
         phase_ticks <= phase_ticks + 9'h001;
      end
   end

   always_comb begin
      phase_err = 1'b0;
      if (pin_edge && pin_last && error_monitor_mode_select_i) begin
         phase_err = phase_ticks < ({1'b0, high_min} + 9'h001);
      end else if (!pin_edge && !overrun_done) begin
         if (pin_sync && error_monitor_mode_select_i) begin
            phase_err = phase_ticks > {1'b0, high_max};
         end else if (!pin_sync) begin
            phase_err = phase_ticks > {1'b0, low_max};
         end
      end
   end

   // one event per overrun phase, not one per tick
   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i || !esm_en || pin_edge) begin
         overrun_done <= 1'b0;
      end else if (phase_err) begin
         overrun_done <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || power_on_reset_i) begin
         error_monitor_event_o <= 1'b0;
         error_monitor_fail_count_o <= '0;
      end else begin
         error_monitor_event_o <= esm_en && phase_err;
         if (esm_en && phase_err && error_monitor_fail_count_o != '1) begin
            error_monitor_fail_count_o <= error_monitor_fail_count_o + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || power_on_reset_i);

   sequence s_leave_armed;
      in_diag && leave_req && !diagnostic_leave_block_i;
   endsequence
   sequence s_safe_entry;
      dev_state_i != scm_pkg::SCM_SAFE ##1 dev_state_i == scm_pkg::SCM_SAFE;
   endsequence

   a_ctrl_lock_hold: assert property (cmd_valid_i && cmd_i.write && ctrl_lock_i
      && dev_state_i != scm_pkg::SCM_SAFE |=> $stable({crc_en, drive_en, esm_en}))
      else $error("control changed while locked");
   a_window_gate: assert property (cmd_valid_i && cmd_i.write && (!in_diag || cfg_lock_i)
      |=> $stable({high_max, high_min, low_max}))
      else $error("window written outside diagnostic");
   a_leave_clear: assert property (!in_diag |=> !leave_req)
      else $error("leave request kept outside diagnostic");
   a_leave_exit: assert property (s_leave_armed |=> diagnostic_leave_o)
      else $error("leave request not forwarded");
   a_safe_clears_drive: assert property (s_safe_entry |=> !drive_en)
      else $error("drive enable survived safe entry");
   a_pin_low_off: assert property (!drive_en |=> !drive_enable_pin_o)
      else $error("pin high with drive disabled");
   a_pin_counts: assert property (drive_enable_pin_o |-> $past(fail_i.wd_count < fail_i.wd_reset_th))
      else $error("pin high with watchdog count at threshold");
   a_monitor_off: assert property (!esm_en |=> !error_monitor_event_o)
      else $error("monitor event while disabled");
   a_crc_off: assert property (!crc_en |=> !checksum_error_o)
      else $error("checksum error while check disabled");
   a_reserved_zero: assert property (cmd_valid_i && !cmd_i.write && cmd_i.index == `SCM_IDX_CTRL
      |=> rd_valid_o && rd_data_o[7:5] == 3'h0 && !rd_data_o[1])
      else $error("reserved control bits read nonzero");
   a_step_length: assert property (step_tick && error_monitor_mode_select_i |-> step_cnt == 9'h12b)
      else $error("pulse-width step not 15 us");
   a_step_legacy: assert property (step_tick && !error_monitor_mode_select_i |-> step_cnt == 9'h063)
      else $error("legacy step not 5 us");
   // state gating of pin and leave request, outcomes of permitted writes and of monitor events
   a_pin_state: assert property (drive_enable_pin_o
      |-> $past(in_diag || dev_state_i == scm_pkg::SCM_ACTIVE))
      else $error("pin high outside active or diagnostic");
   a_window_land: assert property (win_wr && cmd_i.index == `SCM_IDX_LMAX
      |=> low_max == $past(cmd_i.wdata))
      else $error("permitted window write lost");
   a_leave_rise: assert property ($rose(leave_req) |-> $past(in_diag))
      else $error("leave request set outside diagnostic");
   a_fail_step: assert property (error_monitor_event_o && $past(error_monitor_fail_count_o) != '1
      |-> error_monitor_fail_count_o == FC_WIDTH'($past(error_monitor_fail_count_o) + 1'b1))
      else $error("failure count did not follow event");
endmodule // scm_safety_cfg
`default_nettype wire

// File: include/scm_consts.svh
// scm_consts.svh: register indices, field positions, reset values and timing constants
// assumes a 20 MHz device clock
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_IDX_CTRL 3'h0
`define SCM_IDX_HMAX 3'h1
`define SCM_IDX_HMIN 3'h2
`define SCM_IDX_LMAX 3'h3
`define SCM_BIT_CRC_EN 4
`define SCM_BIT_DRV_EN 3
`define SCM_BIT_ESM_EN 2
`define SCM_BIT_LEAVE 0
`define SCM_RST_CTRL 8'h00
`define SCM_RST_HMAX 8'ha8
`define SCM_RST_HMIN 8'ha7
`define SCM_RST_LMAX 8'h3d
`define SCM_CLK_KHZ 20000
`define SCM_STEP_PWM_NS 15000
`define SCM_STEP_LEGACY_NS 5000
`define SCM_CRC_POLY 8'h07
`define SCM_CRC_INIT 8'hff
`endif

// File: include/scm_pkg.sv
// scm_pkg: types shared by the safety-check configuration block
// assumes nothing beyond the constants header
`default_nettype none
package scm_pkg;
   // device operating state, gray coded along init -> diag -> active -> safe
   typedef enum logic [1:0] {
      SCM_INIT = 2'h0,
      SCM_DIAG = 2'h1,
      SCM_ACTIVE = 2'h3,
      SCM_SAFE = 2'h2
   } scm_state_type;
   typedef struct packed {
      logic write;
      logic [2:0] index;
      logic [7:0] wdata;
   } scm_cmd_type;
   typedef struct packed {
      logic [3:0] wd_count;
      logic [3:0] wd_drive_th;
      logic [3:0] wd_reset_th;
      logic [3:0] esm_drive_th;
   } scm_fail_type;
endpackage
`default_nettype wire

// File: sim/scm_host_model.sv
// scm_host_model: host side of the error pin, drives timed phases on request
// assumes the bench calls drive_phase from the clk_i domain
`default_nettype none
module scm_host_model (
   input wire logic clk_i,
   output logic error_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // starts high: a healthy host before the first driven phase; holds the last driven level after each phase
   initial error_pin_o = 1'b1;
   task automatic drive_phase(input logic lvl, input int n);
      @(posedge clk_i);
      error_pin_o <= lvl;
      repeat (n - 1) @(posedge clk_i);
   endtask
endmodule // scm_host_model
`default_nettype wire

// File: sim/tb_scm_safety_cfg.sv
// tb_scm_safety_cfg: directed bench for the safety-check configuration block
// assumes one clk_i domain; registers reached through the command port
`default_nettype none
`include "scm_consts.svh"
module tb_scm_safety_cfg;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, por, cmd_valid, ctrl_lock, cfg_lock, leave_block, mode;
   scm_pkg::scm_cmd_type cmd;
   scm_pkg::scm_state_type st;
   scm_pkg::scm_fail_type fail;
   logic [7:0] exp_crc, rd_data;
   logic rd_valid, pin, leave, crc_err, ev, err_pin;
   logic [3:0] fcount;
   int n_mismatch = 0, total_checks = 0, n_ev = 0;
   scm_safety_cfg i_scm_safety_cfg (.clk_i(clk_i), .rst_i(rst_i), .power_on_reset_i(por),
      .cmd_valid_i(cmd_valid), .cmd_i(cmd), .ctrl_lock_i(ctrl_lock), .cfg_lock_i(cfg_lock),
      .dev_state_i(st), .diagnostic_leave_block_i(leave_block), .error_monitor_mode_select_i(mode),
      .expected_config_checksum_i(exp_crc), .fail_i(fail), .error_pin_i(err_pin),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .drive_enable_pin_o(pin),
      .diagnostic_leave_o(leave), .checksum_error_o(crc_err), .error_monitor_event_o(ev),
      .error_monitor_fail_count_o(fcount));
   scm_host_model i_scm_host_model (.clk_i(clk_i), .error_pin_o(err_pin));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (ev === 1'b1) n_ev++;
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string msg);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, want);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic access(input logic wr, input logic [2:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd <= '{wr, idx, d};
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [2:0] idx, input logic [7:0] want, input string msg);
      access(1'b0, idx, 8'h00);
      check(8'(rd_valid), 8'h01, msg);
      check(rd_data, want, msg);
   endtask
   task automatic pin_case(input scm_pkg::scm_fail_type f, input logic want);
      @(posedge clk_i);
      fail <= f;
      cyc(2);
      check(8'(pin), 8'(want), "drive pin");
   endtask
   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = `SCM_CRC_INIT;
      for (int i = 31; i >= 0; i--) begin
         c = c[7] ^ d[i] ? {c[6:0], 1'b0} ^ `SCM_CRC_POLY : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   task automatic set_state(input scm_pkg::scm_state_type s);
      @(posedge clk_i);
      st <= s;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk(`SCM_IDX_CTRL, `SCM_RST_CTRL, "ctrl reset");
      rd_chk(`SCM_IDX_HMAX, `SCM_RST_HMAX, "hmax reset");
      rd_chk(`SCM_IDX_HMIN, `SCM_RST_HMIN, "hmin reset");
      rd_chk(`SCM_IDX_LMAX, `SCM_RST_LMAX, "lmax reset");
      rd_chk(3'h5, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_locks;
      set_state(scm_pkg::SCM_ACTIVE);
      access(1'b1, `SCM_IDX_HMAX, 8'h11);
      rd_chk(`SCM_IDX_HMAX, `SCM_RST_HMAX, "window write outside diag");
      set_state(scm_pkg::SCM_DIAG);
      cfg_lock <= 1'b1;
      access(1'b1, `SCM_IDX_HMAX, 8'h11);
      rd_chk(`SCM_IDX_HMAX, `SCM_RST_HMAX, "window write locked");
      @(posedge clk_i);
      cfg_lock <= 1'b0;
      access(1'b1, `SCM_IDX_HMAX, 8'h11);
      rd_chk(`SCM_IDX_HMAX, 8'h11, "window write");
      access(1'b1, `SCM_IDX_CTRL, 8'hf6);
      rd_chk(`SCM_IDX_CTRL, 8'h14, "reserved bits");
      @(posedge clk_i);
      ctrl_lock <= 1'b1;
      access(1'b1, `SCM_IDX_CTRL, 8'h00);
      rd_chk(`SCM_IDX_CTRL, 8'h14, "ctrl write locked");
      @(posedge clk_i);
      ctrl_lock <= 1'b0;
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`SCM_IDX_CTRL, `SCM_RST_CTRL, "ctrl after device reset");
      rd_chk(`SCM_IDX_HMAX, 8'h11, "window kept on device reset");
      @(posedge clk_i);
      por <= 1'b1;
      @(posedge clk_i);
      por <= 1'b0;
      rd_chk(`SCM_IDX_HMAX, `SCM_RST_HMAX, "window after power-on");
      $display("test locks done");
   endtask
   task automatic t_crc;
      @(posedge clk_i);
      // expected value goes in before the check is switched on
      exp_crc <= crc8({`SCM_RST_HMAX, `SCM_RST_HMIN, `SCM_RST_LMAX, 7'h00, mode});
      access(1'b1, `SCM_IDX_CTRL, 8'h10);
      cyc(2);
      check(8'(crc_err), 8'h00, "crc match");
      @(posedge clk_i);
      exp_crc <= ~exp_crc;
      cyc(2);
      check(8'(crc_err), 8'h01, "crc mismatch");
      access(1'b1, `SCM_IDX_CTRL, 8'h00);
      cyc(2);
      check(8'(crc_err), 8'h00, "crc disabled");
      $display("test crc done");
   endtask
   task automatic t_leave;
      set_state(scm_pkg::SCM_ACTIVE);
      access(1'b1, `SCM_IDX_CTRL, 8'h01);
      rd_chk(`SCM_IDX_CTRL, 8'h00, "leave outside diag");
      set_state(scm_pkg::SCM_DIAG);
      access(1'b1, `SCM_IDX_CTRL, 8'h01);
      cyc(1);
      check(8'(leave), 8'h00, "leave blocked");
      @(posedge clk_i);
      leave_block <= 1'b0;
      cyc(2);
      check(8'(leave), 8'h01, "leave request");
      set_state(scm_pkg::SCM_ACTIVE);
      cyc(1);
      rd_chk(`SCM_IDX_CTRL, 8'h00, "leave cleared");
      $display("test leave done");
   endtask
   task automatic t_drive;
      pin_case('{4'h1, 4'h2, 4'h2, 4'h1}, 1'b0);
      access(1'b1, `SCM_IDX_CTRL, 8'h08);
      pin_case('{4'h1, 4'h2, 4'h2, 4'h1}, 1'b1);
      set_state(scm_pkg::SCM_INIT);
      pin_case('{4'h1, 4'h2, 4'h2, 4'h1}, 1'b0);
      set_state(scm_pkg::SCM_ACTIVE);
      pin_case('{4'h2, 4'h3, 4'h2, 4'h1}, 1'b0);
      pin_case('{4'h2, 4'h2, 4'h3, 4'h1}, 1'b0);
      pin_case('{4'h1, 4'h2, 4'h2, 4'h0}, 1'b0);
      pin_case('{4'h1, 4'h2, 4'h2, 4'h4}, 1'b1);
      set_state(scm_pkg::SCM_DIAG);
      pin_case('{4'h1, 4'h2, 4'h2, 4'h4}, 1'b1);
      set_state(scm_pkg::SCM_SAFE);
      pin_case('{4'h1, 4'h2, 4'h2, 4'h4}, 1'b0);
      rd_chk(`SCM_IDX_CTRL, 8'h00, "drive bit on safe entry");
      $display("test drive done");
   endtask
   task automatic t_monitor;
      int base;
      set_state(scm_pkg::SCM_DIAG);
      access(1'b1, `SCM_IDX_LMAX, 8'h01);
      base = n_ev;
      i_scm_host_model.drive_phase(1'b0, 400);
      i_scm_host_model.drive_phase(1'b1, 100);
      check(8'(n_ev - base), 8'h00, "monitor disabled");
      access(1'b1, `SCM_IDX_CTRL, 8'h04);
      i_scm_host_model.drive_phase(1'b0, 400);
      i_scm_host_model.drive_phase(1'b0, 120);
      check(8'(n_ev - base), 8'h01, "legacy low max");
      i_scm_host_model.drive_phase(1'b1, 100);
      mode <= 1'b1;
      access(1'b1, `SCM_IDX_HMIN, 8'h03);
      access(1'b1, `SCM_IDX_HMAX, 8'h05);
      i_scm_host_model.drive_phase(1'b1, 1500);
      // same low length as above stays inside the coarser window
      i_scm_host_model.drive_phase(1'b0, 400);
      check(8'(n_ev - base), 8'h01, "pulse low max scale");
      i_scm_host_model.drive_phase(1'b1, 350);
      i_scm_host_model.drive_phase(1'b0, 100);
      check(8'(n_ev - base), 8'h02, "pulse high min");
      i_scm_host_model.drive_phase(1'b1, 2400);
      check(8'(n_ev - base), 8'h03, "pulse high max");
      check(8'(fcount), 8'h03, "fail count");
      $display("test monitor done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      n_mismatch++;
      $display("unexpected at %0t: run limit reached", $time);
      complete_run();
   end
   initial begin
      rst_i = 1'b1;
      por = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      ctrl_lock = 1'b0;
      cfg_lock = 1'b0;
      leave_block = 1'b1;
      mode = 1'b0;
      st = scm_pkg::SCM_INIT;
      fail = '0;
      exp_crc = 8'h00;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      por <= 1'b0;
      t_reset();
      t_locks();
      t_crc();
      t_leave();
      t_drive();
      t_monitor();
      complete_run();
   end
endmodule // tb_scm_safety_cfg
`default_nettype wire
